// ==== hw/bsq_brake_seq.sv ====
// Top: brake sequencer with overtravel warning and APB registers
// Function
// - Warn when either travel-prohibit input is active with servo on.
// - Warning detection setting: 0 off, 1 on; on by default, immediate.
// - On warning, stop motor but keep accepting controller commands.
// - Brake output high releases brake, low engages it.
// - Servo off or alarm: engage after wait time or below velocity.
// - After engaging on servo off at rest or on alarm stop done, keep motor powered for poweroff delay, then disable.
// - Servo off while stopped drops brake output at once.
// - Poweroff delay 0 to 50 in 10 ms, default 10, immediate.
// - Alarm with motor stopped disables motor at once.
// - Power off: engage on low velocity or wait elapsed, whichever first.
// - Zero-velocity alarm stop runs the poweroff delay once stopped.
// - Rotary threshold 0 to 10000 rpm, default 100.
// - Servo-off wait 10 to 100 in 10 ms, default 50, immediate.
// - Linear threshold 0 to 10000 mm/s, default 10.
// - In overtravel, brake stays released while output asserted.
// - Brake output routable to a selectable pin.
// - In overtravel, motion opposite the prohibited side is allowed.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module bsq_brake_seq
  import bsq_pkg::*;
#(
  parameter int TICK_DIVIDE = TICK_CYCLES,
  parameter int VEL_WIDTH = 16,
  parameter int PINS = 8
) (
  input wire logic ref_clk, // System clock, 250 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic servoOnIn, // Servo-on request pin
  input wire logic alarm, // Drive alarm level
  input wire logic forward_travel_prohibit, // Forward limit active
  input wire logic reverse_travel_prohibit, // Reverse limit active
  input wire logic signed [VEL_WIDTH-1:0] motorVelocity, // Signed speed
  input wire logic stopDone, // Zero-velocity alarm stop finished
  output logic brake_control_out, // High releases brake
  output logic motorPower, // Motor power enabled
  output logic overtravel_warning, // Overtravel warning
  output logic motorStop, // Stop request to motion control
  output logic forwardAllowed, // Forward motion permitted
  output logic reverseAllowed, // Reverse motion permitted
  output logic [PINS-1:0] outPins // Routed output pins
);
  typedef struct packed {
    bsq_state_type state;
    logic servoOnSw;
    logic linearMotor;
    logic warnDetect;
    logic [5:0] poweroffDelay;
    logic [13:0] rotaryVel;
    logic [6:0] offWait;
    logic [13:0] linearVel;
    logic [2:0] pinAssign;
    logic [2:0] warnAssign;
    logic [6:0] timer;
    logic brake;
    logic power;
    logic warn;
    logic stop;
    logic fwdOk;
    logic revOk;
    logic [PINS-1:0] pins;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } bsq_top_state_type;

  bsq_top_state_type r;
  bsq_top_state_type next_r;
  logic tick;
  logic [PINS-1:0] routed;
  logic [VEL_WIDTH-1:0] absVel;
  logic slow;
  logic servoOn;
  logic overtravel;
  logic access;

  // Clamp a written field into its legal range
  function automatic logic [13:0] clampVel(input logic [31:0] v);
    if (v > 32'(VEL_MAX)) begin
      clampVel = VEL_MAX;
    end else begin
      clampVel = v[13:0];
    end
  endfunction : clampVel

  bsq_tick #(
    .DIVIDE(TICK_DIVIDE)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  bsq_pin_route #(
    .PINS(PINS)
  ) u_route (
    .brakeLevel(next_r.brake),
    .warnLevel(next_r.warn),
    .brakeSel(r.pinAssign),
    .warnSel(r.warnAssign),
    .pinLevel(routed)
  );

  // Magnitude so that reverse motion is judged like forward
  assign absVel = motorVelocity[VEL_WIDTH-1] ?
    VEL_WIDTH'(-motorVelocity) : motorVelocity;
  assign slow = r.linearMotor ?
    (32'(absVel) < 32'(r.linearVel)) :
    (32'(absVel) < 32'(r.rotaryVel));
  assign servoOn = servoOnIn && r.servoOnSw;
  assign overtravel = forward_travel_prohibit || reverse_travel_prohibit;
  assign access = psel && penable;

  always_comb begin
    next_r = r;
    next_r.ready = 1'b0;
    next_r.slverr = 1'b0;
    // Register bus: one wait state, answer on second access cycle
    if (access && !r.ready) begin
      next_r.ready = 1'b1;
      next_r.rdata = 32'h00000000;
      if (pwrite) begin
        case (paddr)
          REG_CTRL: begin
            next_r.servoOnSw = pwdata[CTRL_SERVO_ON_BIT];
            next_r.linearMotor = pwdata[CTRL_LINEAR_BIT];
          end
          REG_WARN_DETECT: next_r.warnDetect = pwdata[0];
          REG_POWEROFF_DELAY: begin
            next_r.poweroffDelay = (pwdata > 32'(POWEROFF_DELAY_MAX)) ?
              POWEROFF_DELAY_MAX : pwdata[5:0];
          end
          REG_ROTARY_VEL: next_r.rotaryVel = clampVel(pwdata);
          REG_OFF_WAIT: begin
            if (pwdata < 32'(OFF_WAIT_MIN)) begin
              next_r.offWait = OFF_WAIT_MIN;
            end else if (pwdata > 32'(OFF_WAIT_MAX)) begin
              next_r.offWait = OFF_WAIT_MAX;
            end else begin
              next_r.offWait = pwdata[6:0];
            end
          end
          REG_LINEAR_VEL: next_r.linearVel = clampVel(pwdata);
          REG_PIN_ASSIGN: next_r.pinAssign = pwdata[2:0];
          REG_WARN_ASSIGN: next_r.warnAssign = pwdata[2:0];
          default: next_r.slverr = 1'b1;
        endcase
      end else begin
        case (paddr)
          REG_CTRL: next_r.rdata = {30'h0, r.linearMotor, r.servoOnSw};
          REG_WARN_DETECT: next_r.rdata = {31'h0, r.warnDetect};
          REG_POWEROFF_DELAY: next_r.rdata = {26'h0, r.poweroffDelay};
          REG_ROTARY_VEL: next_r.rdata = {18'h0, r.rotaryVel};
          REG_OFF_WAIT: next_r.rdata = {25'h0, r.offWait};
          REG_LINEAR_VEL: next_r.rdata = {18'h0, r.linearVel};
          REG_PIN_ASSIGN: next_r.rdata = {29'h0, r.pinAssign};
          REG_WARN_ASSIGN: next_r.rdata = {29'h0, r.warnAssign};
          REG_STATUS: begin
            next_r.rdata = {20'h0, r.fwdOk, r.revOk, r.stop, r.warn,
              r.power, r.brake, 1'b0, r.state};
          end
          default: next_r.slverr = 1'b1;
        endcase
      end
    end

    // Overtravel warning follows its cause level by level
    next_r.warn = r.warnDetect && servoOn && overtravel;
    // Stop request only; command interface stays open to the controller
    next_r.stop = next_r.warn;
    next_r.fwdOk = !forward_travel_prohibit;
    next_r.revOk = !reverse_travel_prohibit;

    // Brake sequencer
    case (r.state)
      ST_OFF: begin
        next_r.brake = 1'b0;
        next_r.power = 1'b0;
        next_r.timer = 7'h00;
        if (servoOn && !alarm) begin
          next_r.state = ST_RUN;
          next_r.power = 1'b1;
          next_r.brake = 1'b1;
        end
      end
      ST_RUN: begin
        // Overtravel alone never touches the brake output
        next_r.brake = 1'b1;
        next_r.power = 1'b1;
        next_r.timer = 7'h00;
        if (alarm && slow) begin
          // Stopped motor: no delay, load may creep before brake holds
          next_r.brake = 1'b0;
          next_r.power = 1'b0;
          next_r.state = ST_OFF;
        end else if (alarm && stopDone) begin
          next_r.brake = 1'b0;
          next_r.state = ST_HOLD;
        end else if (alarm) begin
          next_r.power = 1'b0;
          next_r.state = ST_STOPPING;
        end else if (!servoOn && slow) begin
          next_r.brake = 1'b0;
          next_r.state = ST_HOLD;
        end else if (!servoOn) begin
          next_r.power = 1'b0;
          next_r.state = ST_STOPPING;
        end
      end
      ST_STOPPING: begin
        // Motor coasting unpowered; first of velocity or wait wins
        if (tick) begin
          next_r.timer = r.timer + 7'h01;
        end
        if (slow || r.timer >= r.offWait) begin
          next_r.brake = 1'b0;
          next_r.timer = 7'h00;
          next_r.state = ST_ALARM_HOLD;
        end
      end
      ST_HOLD: begin
        // Power kept on while the brake bites
        if (tick) begin
          next_r.timer = r.timer + 7'h01;
        end
        if (r.timer >= 7'(r.poweroffDelay)) begin
          next_r.power = 1'b0;
          next_r.timer = 7'h00;
          next_r.state = ST_OFF;
        end
      end
      ST_ALARM_HOLD: begin
        // Brake engaged; settle before a new servo-on is honoured
        next_r.brake = 1'b0;
        next_r.power = 1'b0;
        if (!servoOn || !alarm) begin
          next_r.state = ST_OFF;
        end
      end
      default: begin
        next_r.state = ST_OFF;
        next_r.brake = 1'b0;
        next_r.power = 1'b0;
      end
    endcase
    next_r.pins = routed;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.state <= ST_OFF;
      r.servoOnSw <= 1'b1;
      r.warnDetect <= WARN_DETECT_RESET;
      r.poweroffDelay <= POWEROFF_DELAY_RESET;
      r.rotaryVel <= ROTARY_VEL_RESET;
      r.offWait <= OFF_WAIT_RESET;
      r.linearVel <= LINEAR_VEL_RESET;
      r.pinAssign <= PIN_ASSIGN_RESET;
      r.warnAssign <= WARN_ASSIGN_RESET;
      r.fwdOk <= 1'b1;
      r.revOk <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.rdata;
  assign pready = r.ready;
  assign pslverr = r.slverr;
  assign brake_control_out = r.brake;
  assign motorPower = r.power;
  assign overtravel_warning = r.warn;
  assign motorStop = r.stop;
  assign forwardAllowed = r.fwdOk;
  assign reverseAllowed = r.revOk;
  assign outPins = r.pins;
endmodule : bsq_brake_seq
`default_nettype wire

// ==== hw/bsq_pin_route.sv ====
// Routes brake and warning signals onto a bank of output pins
`timescale 1ns/1ns
`default_nettype none
module bsq_pin_route
  import bsq_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic brakeLevel, // Brake control level
  input wire logic warnLevel, // Warning level
  input wire logic [2:0] brakeSel, // Pin index for brake output
  input wire logic [2:0] warnSel, // Pin index for warning, 0 is none
  output logic [PINS-1:0] pinLevel // Combined pin levels
);
  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      assign pinLevel[i] = (brakeLevel && brakeSel == 3'(i)) ||
        (warnLevel && warnSel != 3'h0 && warnSel == 3'(i));
    end
  endgenerate
endmodule : bsq_pin_route
`default_nettype wire

// ==== hw/bsq_pkg.sv ====
// Package: constants, register map and types for the brake sequencer
package bsq_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WARN_DETECT = 8'h04;
  localparam logic [7:0] REG_POWEROFF_DELAY = 8'h08;
  localparam logic [7:0] REG_ROTARY_VEL = 8'h0C;
  localparam logic [7:0] REG_OFF_WAIT = 8'h10;
  localparam logic [7:0] REG_LINEAR_VEL = 8'h14;
  localparam logic [7:0] REG_PIN_ASSIGN = 8'h18;
  localparam logic [7:0] REG_WARN_ASSIGN = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  // Control field positions
  localparam int CTRL_SERVO_ON_BIT = 0;
  localparam int CTRL_LINEAR_BIT = 1;
  // Reset values and field limits
  localparam logic WARN_DETECT_RESET = 1'b1;
  localparam logic [5:0] POWEROFF_DELAY_RESET = 6'h0A;
  localparam logic [5:0] POWEROFF_DELAY_MAX = 6'h32;
  localparam logic [13:0] ROTARY_VEL_RESET = 14'h0064;
  localparam logic [13:0] LINEAR_VEL_RESET = 14'h000A;
  localparam logic [13:0] VEL_MAX = 14'h2710;
  localparam logic [6:0] OFF_WAIT_RESET = 7'h32;
  localparam logic [6:0] OFF_WAIT_MIN = 7'h0A;
  localparam logic [6:0] OFF_WAIT_MAX = 7'h64;
  localparam logic [2:0] PIN_ASSIGN_RESET = 3'h5;
  localparam logic [2:0] WARN_ASSIGN_RESET = 3'h0;
  // Tick timing
  localparam int CLOCK_MHZ = 250;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLOCK_MHZ * 1000 * TICK_MS;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_RUN = 5'h02,
    ST_STOPPING = 5'h04,
    ST_HOLD = 5'h08,
    ST_ALARM_HOLD = 5'h10
  } bsq_state_type;
endpackage : bsq_pkg

// ==== hw/bsq_tick.sv ====
// Divider giving a one-cycle enable every 10 ms
`timescale 1ns/1ns
`default_nettype none
module bsq_tick
  import bsq_pkg::*;
#(
  parameter int DIVIDE = TICK_CYCLES
) (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  output logic tick // One-cycle pulse each period
);
  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } bsq_tick_state_type;
  bsq_tick_state_type r;
  bsq_tick_state_type next_r;
  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.count >= 32'(DIVIDE - 1)) begin
      next_r.count = 32'h00000000;
      next_r.tick = 1'b1;
    end else begin
      next_r.count = r.count + 32'h00000001;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign tick = r.tick;
endmodule : bsq_tick
`default_nettype wire

// ==== tb/bsq_brake_relay.sv ====
// Relay-driven holding brake at the brake output
`timescale 1ns/1ns
`default_nettype none
module bsq_brake_relay #(
  parameter int LAG = 3
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic brakeCmd, // High releases the brake
  output logic brakeHeld // High while the brake grips
);
  int n;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      n <= 0;
      brakeHeld <= 1'b1;
    end else if (brakeCmd == brakeHeld) begin
      n <= n + 1;
      if (n >= LAG) begin
        brakeHeld <= !brakeCmd; // Coil moves only after the relay lag
        n <= 0;
      end
    end else begin
      n <= 0;
    end
  end
endmodule : bsq_brake_relay
`default_nettype wire

// ==== tb/bsq_brake_seq_sva.sv ====
// Port assertions for the brake sequencer
`timescale 1ns/1ns
`default_nettype none
module bsq_brake_seq_sva #(
  parameter int VEL_WIDTH = 16
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic servoOnIn, // Servo-on pin
  input wire logic alarm, // Alarm level
  input wire logic forward_travel_prohibit, // Forward limit
  input wire logic reverse_travel_prohibit, // Reverse limit
  input wire logic signed [VEL_WIDTH-1:0] motorVelocity, // Speed
  input wire logic stopDone, // Alarm stop done
  input wire logic brake_control_out, // High releases brake
  input wire logic motorPower, // Motor powered
  input wire logic overtravel_warning, // Warning
  input wire logic motorStop, // Stop request
  input wire logic forwardAllowed, // Forward permitted
  input wire logic reverseAllowed // Reverse permitted
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_run;
    brake_control_out && motorPower;
  endsequence
  sequence s_halt;
    !servoOnIn && !alarm && motorVelocity == 0;
  endsequence
  warn_stop_a: assert property (
    motorStop == overtravel_warning) else $error("stop differs from warning");
  warn_clear_a: assert property (
    !servoOnIn || !(forward_travel_prohibit || reverse_travel_prohibit)
    |=> !overtravel_warning) else $error("warning without cause");
  fwd_allow_a: assert property (
    1 |=> forwardAllowed == !$past(forward_travel_prohibit))
    else $error("forward permit wrong");
  rev_allow_a: assert property (
    reverse_travel_prohibit |=> !reverseAllowed)
    else $error("reverse permit wrong");
  release_why_a: assert property (
    $rose(brake_control_out) |-> $past(servoOnIn) && !$past(alarm))
    else $error("brake released without servo on");
  engage_why_a: assert property (
    $fell(brake_control_out)
    |-> !$past(servoOnIn) || $past(alarm) || !$past(motorPower))
    else $error("brake engaged without cause");
  off_still_a: assert property (
    s_run ##0 s_halt |=> !brake_control_out && motorPower)
    else $error("brake kept after servo off at rest");
  alarm_still_a: assert property (
    s_run ##0 (alarm && motorVelocity == 0)
    |=> !(brake_control_out || motorPower)) else $error("power kept");
  alarm_hold_a: assert property (
    s_run ##0 (alarm && stopDone && motorVelocity > 10000)
    |=> !brake_control_out && motorPower) else $error("stop hold wrong");
  ready_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
endmodule : bsq_brake_seq_sva
`default_nettype wire

// ==== tb/bsq_brake_seq_test.sv ====
// Bench: registers, brake sequence and warning of the sequencer
`timescale 1ns/1ns
`default_nettype none
module bsq_brake_seq_test;
  import bsq_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, held, warn, mStop, fOk, rOk, brk, pwr;
  logic servoOn = 1'b0, alarm = 1'b0, fLim = 1'b0, rLim = 1'b0;
  logic stopDone = 1'b0;
  logic signed [15:0] vel = 16'sh0;
  logic [7:0] pins;
  int error_cnt = 0, comparisons = 0, cyc = 0, n;
  int mdl [8] = '{1, 1, 10, 100, 50, 10, 5, 0};
  always #2 ref_clk = ~ref_clk;
  bsq_brake_seq #(.TICK_DIVIDE(10)) uut (.ref_clk(ref_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .servoOnIn(servoOn), .alarm(alarm),
    .forward_travel_prohibit(fLim), .reverse_travel_prohibit(rLim),
    .motorVelocity(vel), .stopDone(stopDone), .brake_control_out(brk),
    .motorPower(pwr), .overtravel_warning(warn), .motorStop(mStop),
    .forwardAllowed(fOk), .reverseAllowed(rOk), .outPins(pins));
  bsq_brake_relay #(.LAG(3)) relay (.ref_clk(ref_clk), .rst_n(rst_n),
    .brakeCmd(brk), .brakeHeld(held));
  task automatic complete_run();
    $display("errors %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, x);
    comparisons++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : tick
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge ref_clk);
    penable <= 1'b1;
    // No cycle count assumed; the bench watchdog ends a lost answer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic int lim(input int a, input int v);
    case (a)
      8: return v > 50 ? 50 : v;
      12, 20: return v > 10000 ? 10000 : v;
      16: return v < 10 ? 10 : (v > 100 ? 100 : v);
      default: return v;
    endcase
  endfunction : lim
  task automatic rd(input logic [7:0] a, input int v);
    apb(1'b0, a, 0);
    chk(q, 32'(v));
  endtask : rd
  task automatic wr(input logic [7:0] a, input int v);
    apb(1'b1, a, v);
    mdl[a / 4] = lim(a, v);
    rd(a, mdl[a / 4]);
  endtask : wr
  // Free-running tick phase makes every timer one tick uncertain
  task automatic fall(input bit usePwr, input int lo, hi);
    n = 0;
    while ((usePwr ? pwr : brk) !== 1'b0 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 1);
  endtask : fall
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    n = $urandom(32'h4525);
    tick(3);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(8'(4 * i), mdl[i]);
    apb(1'b0, 8'h24, 0);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, REG_STATUS, 0);
    chk(32'(e), 32'h1);
    wr(REG_POWEROFF_DELAY, 63);
    wr(REG_OFF_WAIT, 5);
    wr(REG_OFF_WAIT, 200);
    wr(REG_ROTARY_VEL, 20000);
    wr(REG_LINEAR_VEL, $urandom % 10001);
    wr(REG_ROTARY_VEL, 100);
    wr(REG_LINEAR_VEL, 10);
    wr(REG_POWEROFF_DELAY, 2);
    wr(REG_OFF_WAIT, 10);
    servoOn <= 1'b1;
    tick(8);
    chk(32'({brk, pwr, held}), 32'h6);
    servoOn <= 1'b0;
    tick(2);
    chk(32'({brk, pwr}), 32'h1);
    fall(1'b1, 8, 21);
    tick(6);
    chk(32'(held), 32'h1);
    vel <= 16'sh1F4;
    servoOn <= 1'b1;
    tick(3);
    servoOn <= 1'b0;
    tick(2);
    chk(32'({brk, pwr}), 32'h2);
    fall(1'b0, 85, 102);
    servoOn <= 1'b1;
    tick(3);
    servoOn <= 1'b0;
    tick(20);
    vel <= -16'sh32; // Reverse speed inside the threshold
    fall(1'b0, 1, 3);
    vel <= 16'sh0;
    servoOn <= 1'b1;
    tick(3);
    alarm <= 1'b1;
    tick(2);
    chk(32'({brk, pwr}), 32'h0);
    alarm <= 1'b0;
    vel <= 16'sh2EE0; // Above every settable threshold
    tick(3);
    alarm <= 1'b1;
    stopDone <= 1'b1;
    tick(2);
    chk(32'({brk, pwr}), 32'h1);
    fall(1'b1, 8, 21);
    alarm <= 1'b0;
    stopDone <= 1'b0;
    tick(3);
    chk(32'({pins[5], brk}), 32'h3);
    for (int i = 0; i < 2; i++) begin
      fLim <= (i == 0);
      rLim <= (i == 1);
      tick(3);
      chk(32'({warn, mStop, brk}), 32'h7);
      chk(32'({fOk, rOk}), 32'({i == 1, i == 0}));
    end
    wr(REG_WARN_ASSIGN, 3);
    chk(32'(pins[3]), 32'h1);
    wr(REG_WARN_DETECT, 0);
    tick(2);
    chk(32'({warn, pins[3]}), 32'h0);
    rLim <= 1'b0;
    wr(REG_CTRL, 3);
    vel <= 16'sh32; // Slow for rotary, fast for linear
    tick(2);
    servoOn <= 1'b0;
    tick(2);
    chk(32'({brk, pwr}), 32'h2);
    fall(1'b0, 85, 102);
    // Software servo-on cleared: pin alone must not release the brake
    wr(REG_CTRL, 2);
    servoOn <= 1'b1;
    tick(3);
    chk(32'({brk, pwr}), 32'h0);
    complete_run();
  end
endmodule : bsq_brake_seq_test
bind bsq_brake_seq bsq_brake_seq_sva #(.VEL_WIDTH(VEL_WIDTH)) sva (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .servoOnIn(servoOnIn), .alarm(alarm),
  .forward_travel_prohibit(forward_travel_prohibit),
  .reverse_travel_prohibit(reverse_travel_prohibit),
  .motorVelocity(motorVelocity), .stopDone(stopDone),
  .brake_control_out(brake_control_out), .motorPower(motorPower),
  .overtravel_warning(overtravel_warning), .motorStop(motorStop),
  .forwardAllowed(forwardAllowed), .reverseAllowed(reverseAllowed));
`default_nettype wire
